//--- ring_fairness_token_control.sv
// Purpose: per-port fairness token engine for a two-port string/loop node
// Assumes: link inputs come from logic on core_clk_i; no synchronisers
// Notes:   one engine per port, i.e. one per traffic direction
//
// Functional notes
// - hold limit is hold base times outstanding
// - idle limit is idle base times outstanding
// - idle base applies when link shows two flags
// - counter counts originations, cleared on token pass
// - only completed, non-aborted frames are counted
// - satisfied at hold limit or nothing to send
// - reflect select picks reflect over forward
// - forwarded token leaves on the other port
// - reflected token leaves same port; return unheld
// - two independent engines, one per direction
// - satisfied passes at once, else hold then pass
// - privileged and control frames are never gated
// - originate when holding unsatisfied or idle headroom
// - below hold limit, holding blocks cut-through
// - between limits, pass token immediately on arrival
// - at idle limit, no application origination
// - accept with sync, transmit only when ready
// - string end reflects fairness token as return
// - dual port node forwards return token unheld
// - string end bounces return token, counter kept

`timescale 1ns/1ps

module ring_fairness_token_control #(
  parameter logic [ring_fairness_pkg::CNT_W-1:0] CNT_SAT =
    ring_fairness_pkg::CNT_MAX
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire ring_fairness_pkg::cfg_t   cfg_i,
  input  wire ring_fairness_pkg::link_in_t  [1:0] link_i,
  output ring_fairness_pkg::link_out_t      [1:0] link_o
);

  localparam int NP = ring_fairness_pkg::NPORTS;
  localparam int CW = ring_fairness_pkg::CNT_W;
  localparam int LW = ring_fairness_pkg::LIM_W;

  if (NP != 2) begin : g_bad_ports
    $error("ring fairness logic serves exactly two ports");
  end
  if (CNT_SAT == ring_fairness_pkg::CNT_RST) begin : g_bad_sat
    $error("counter saturation value must be above zero");
  end

  // the limits must hold the full quota product, or a large
  // outstanding count would wrap the limit below the counter
  if (ring_fairness_pkg::LIM_W <
      ring_fairness_pkg::Q_W + ring_fairness_pkg::OUT_W)
  begin : g_bad_lim
    $error("limit width cannot hold the quota product");
  end
  if (ring_fairness_pkg::CNT_W < ring_fairness_pkg::LIM_W)
  begin : g_bad_cnt
    $error("counter narrower than the limits it is compared with");
  end

  // per-port release and routing requests
  logic [NP-1:0] rel;        // held token passed on this cycle
  logic [NP-1:0] refl;       // this port reflects instead of forwards
  logic [NP-1:0] ret_in;     // return token accepted this cycle
  logic [NP-1:0] set_fair;   // fairness token to queue on port o
  logic [NP-1:0] set_ret;    // return token to queue on port o

  // outbound token queues, one bit each: tokens of one kind merge
  logic [NP-1:0] pend_fair_reg;
  logic [NP-1:0] pend_ret_reg;
  logic [NP-1:0] tx_fair_reg;
  logic [NP-1:0] tx_ret_reg;

  for (genvar p = 0; p < NP; p++) begin : g_port
    localparam int Q = 1 - p;

    ring_fairness_pkg::tok_state_t state_reg;
    ring_fairness_pkg::tok_state_t state_next;

    logic [CW-1:0] cnt_reg;
    logic [LW-1:0] hold_lim;
    logic [LW-1:0] idle_lim;
    logic          satisfied;
    logic          fair_in;
    logic          done_ok;
    logic          prev_flag_reg;
    logic          link_idle_reg;
    logic          may_orig_reg;
    logic          hold_ct_reg;
    logic          sat_reg;
    logic          held;
    logic          orig_held;
    logic          orig_idle;

    // quotas scale with the transfers this port has in flight; both
    // factors are widened first so the product keeps every bit
    assign hold_lim = LW'(cfg_i.hold_base)
                    * LW'(link_i[p].outstanding);
    assign idle_lim = LW'(cfg_i.idle_base)
                    * LW'(link_i[p].outstanding);

    assign held = (state_reg == ring_fairness_pkg::TOK_HELD);

    // a port that already holds a token drops a second copy
    assign fair_in   = link_i[p].rx_fair & link_i[p].char_sync;
    assign ret_in[p] = link_i[p].rx_ret & link_i[p].char_sync;

    assign satisfied = (LW'(cnt_reg) >= hold_lim)
                     | ~link_i[p].have_frames;

    // the end of a string reflects; so does a node told to
    assign refl[p] = cfg_i.reflect | ~link_i[Q].operational;

    assign rel[p] = held & satisfied;

    always_comb begin
      state_next = state_reg;
      case (state_reg)
        ring_fairness_pkg::TOK_FREE: begin
          if (fair_in) begin
            state_next = ring_fairness_pkg::TOK_HELD;
          end
        end
        ring_fairness_pkg::TOK_HELD: begin
          if (satisfied) begin
            state_next = ring_fairness_pkg::TOK_FREE;
          end
        end
        default: state_next = ring_fairness_pkg::TOK_FREE;
      endcase
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        state_reg <= ring_fairness_pkg::TOK_FREE;
      end else begin
        state_reg <= state_next;
      end
    end

    // aborted frames never reach the counter
    assign done_ok = link_i[p].frame_done & ~link_i[p].frame_abort;

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        cnt_reg <= ring_fairness_pkg::CNT_RST;
      end else if (rel[p]) begin
        cnt_reg <= ring_fairness_pkg::CNT_RST;
      end else if (done_ok && cnt_reg < CNT_SAT) begin
        cnt_reg <= cnt_reg + ring_fairness_pkg::CNT_ONE;
      end
    end

    // idle means the two most recent received characters were flags;
    // losing character sync forgets the flag history
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        prev_flag_reg <= 1'b0;
      end else if (!link_i[p].char_sync) begin
        prev_flag_reg <= 1'b0;
      end else if (link_i[p].char_valid) begin
        prev_flag_reg <= link_i[p].char_is_flag;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        link_idle_reg <= 1'b0;
      end else if (!link_i[p].char_sync) begin
        link_idle_reg <= 1'b0;
      end else if (link_i[p].char_valid) begin
        link_idle_reg <= link_i[p].char_is_flag & prev_flag_reg;
      end
    end

    // gating covers application frames only; privileged and
    // control frames are sent without consulting these outputs
    assign orig_held = held & ~satisfied;
    assign orig_idle = ~link_i[p].fwd_pending
                     & link_idle_reg
                     & (idle_lim > LW'(cnt_reg));

    // registered so the frame scheduler sees a clean level, at the
    // cost of one cycle of lag behind the counter
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        may_orig_reg <= 1'b0;
      end else begin
        may_orig_reg <= orig_held | orig_idle;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        hold_ct_reg <= 1'b0;
      end else begin
        hold_ct_reg <= orig_held;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        sat_reg <= 1'b0;
      end else begin
        sat_reg <= satisfied;
      end
    end

    assign link_o[p].tx_fair          = tx_fair_reg[p];
    assign link_o[p].tx_ret           = tx_ret_reg[p];
    assign link_o[p].may_originate    = may_orig_reg;
    assign link_o[p].hold_cut_through = hold_ct_reg;
    assign link_o[p].holding          = state_reg;
    assign link_o[p].satisfied        = sat_reg;
    assign link_o[p].link_idle        = link_idle_reg;
    assign link_o[p].frame_count      = cnt_reg;
  end

  // routing of tokens onto outbound port o, each engine independent
  always_comb begin
    for (int o = 0; o < NP; o++) begin
      // forwarded fairness from the other port, or own bounced return
      set_fair[o] = (rel[1-o] & ~refl[1-o])
                  | (ret_in[o] & refl[o]);
      // reflected fairness on own port, or forwarded return
      set_ret[o]  = (rel[o] & refl[o])
                  | (ret_in[1-o] & ~refl[1-o]);
    end
  end

  // tokens wait until the outbound port is ready; a new request in
  // the emit cycle re-arms the queue so no token is lost
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pend_fair_reg <= '0;
    end else begin
      for (int o = 0; o < NP; o++) begin
        pend_fair_reg[o] <= set_fair[o]
                          | (pend_fair_reg[o] & ~link_i[o].ready);
      end
    end
  end

  // one bit per kind: copies of a token merge, as duplicates should
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pend_ret_reg <= '0;
    end else begin
      for (int o = 0; o < NP; o++) begin
        pend_ret_reg[o] <= set_ret[o]
                         | (pend_ret_reg[o] & ~link_i[o].ready);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_fair_reg <= '0;
    end else begin
      for (int o = 0; o < NP; o++) begin
        tx_fair_reg[o] <= pend_fair_reg[o] & link_i[o].ready;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_ret_reg <= '0;
    end else begin
      for (int o = 0; o < NP; o++) begin
        tx_ret_reg[o] <= pend_ret_reg[o] & link_i[o].ready;
      end
    end
  end

endmodule : ring_fairness_token_control

//--- ring_fairness_pkg.sv
// Purpose: shared types and constants for the ring fairness token logic
// Assumes: two ports per node, all link signals on core_clk_i
// Notes:   widths are sized so the quota products never overflow

package ring_fairness_pkg;

  localparam int NPORTS = 2;
  localparam int Q_W    = 8;   // quota base width
  localparam int OUT_W  = 4;   // outstanding transfer count width
  localparam int LIM_W  = Q_W + OUT_W;
  localparam int CNT_W  = LIM_W;

  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  typedef enum logic {
    TOK_FREE = 1'b0,
    TOK_HELD = 1'b1
  } tok_state_t;

  typedef struct packed {
    logic [Q_W-1:0] hold_base;
    logic [Q_W-1:0] idle_base;
    logic           reflect;
  } cfg_t;

  typedef struct packed {
    logic             char_sync;
    logic             ready;
    logic             operational;
    logic             rx_fair;
    logic             rx_ret;
    logic             char_valid;
    logic             char_is_flag;
    logic             fwd_pending;
    logic             have_frames;
    logic             frame_done;
    logic             frame_abort;
    logic [OUT_W-1:0] outstanding;
  } link_in_t;

  typedef struct packed {
    logic             tx_fair;
    logic             tx_ret;
    logic             may_originate;
    logic             hold_cut_through;
    logic             holding;
    logic             satisfied;
    logic             link_idle;
    logic [CNT_W-1:0] frame_count;
  } link_out_t;

endpackage : ring_fairness_pkg

//--- ring_fairness_properties.sv
// Purpose: timing checks on port 0 of the token engine, plus port 1 transmit timing
// Assumes: config held steady while tokens circulate
// Notes:   bound into every engine instance
`timescale 1ns/1ps
module ring_fairness_properties #(
  parameter logic [ring_fairness_pkg::CNT_W-1:0] CNT_SAT =
    ring_fairness_pkg::CNT_MAX
) (
  input wire logic                               core_clk_i,
  input wire logic                               rst_i,
  input wire ring_fairness_pkg::cfg_t            cfg_i,
  input wire ring_fairness_pkg::link_in_t  [1:0] link_i,
  input wire ring_fairness_pkg::link_out_t [1:0] link_o
);
  ring_fairness_pkg::link_in_t  i0, i1;
  ring_fairness_pkg::link_out_t o0, o1;
  logic                         refl;
  assign {i1, i0} = link_i;
  assign {o1, o0} = link_o;
  assign refl = cfg_i.reflect | ~i1.operational;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  count_step_a: assert property (
    i0.frame_done && !i0.frame_abort && !o0.holding &&
    o0.frame_count < CNT_SAT
    |=> o0.frame_count == $past(o0.frame_count) + 12'h001)
    else $error("counter missed a sent frame");
  abort_kept_a: assert property (
    i0.frame_done && i0.frame_abort && !o0.holding
    |=> $stable(o0.frame_count)) else $error("aborted frame counted");
  release_clear_a: assert property (
    $fell(o0.holding) |-> o0.frame_count == 12'h000)
    else $error("counter kept after token pass");
  token_hold_a: assert property (
    i0.rx_fair && i0.char_sync && !o0.holding |=> o0.holding)
    else $error("token not taken");
  tx_ready_a: assert property (
    o1.tx_fair || o1.tx_ret |-> $past(i1.ready))
    else $error("token sent while not ready");
  forward_route_a: assert property (
    $fell(o0.holding) && !refl && i1.ready |=> o1.tx_fair)
    else $error("token not forwarded");
  reflect_route_a: assert property (
    $fell(o0.holding) && refl && i0.ready |=> o0.tx_ret)
    else $error("token not reflected");
  bounce_route_a: assert property (
    i0.rx_ret && i0.char_sync && refl && i0.ready |-> ##2 o0.tx_fair)
    else $error("return token not bounced");
  cover property (o1.tx_fair);
  cover property (o0.tx_ret);
  cover property (o0.tx_fair);
endmodule : ring_fairness_properties
bind ring_fairness_token_control ring_fairness_properties #(
  .CNT_SAT(CNT_SAT)) chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .cfg_i(cfg_i), .link_i(link_i), .link_o(link_o));

//--- ring_fairness_neighbor.sv
// Purpose: neighbour port feeding tokens and characters to port 0
// Assumes: one token or character per call
// Notes:   flag line flips between characters, never holds old value
`timescale 1ns/1ps
module ring_fairness_neighbor (
  input  wire logic core_clk_i,
  output logic      fair_o,
  output logic      ret_o,
  output logic      char_o,
  output logic      flag_o
);
  initial {fair_o, ret_o, char_o, flag_o} = 4'h0;
  task automatic tok(input logic ret);
    @(negedge core_clk_i);
    fair_o = !ret;
    ret_o = ret;
    @(negedge core_clk_i);
    fair_o = 1'b0;
    ret_o = 1'b0;
  endtask : tok
  task automatic chr(input logic flag);
    @(negedge core_clk_i);
    char_o = 1'b1;
    flag_o = flag;
    @(negedge core_clk_i);
    char_o = 1'b0;
    flag_o = !flag;
  endtask : chr
endmodule : ring_fairness_neighbor

//--- ring_fairness_token_control_bench.sv
// Purpose: directed scenarios for the token engine
// Assumes: counter capped at 7 to reach the cap quickly
// Notes:   port 1 gets its own token scenario for the second direction
`timescale 1ns/1ps
module ring_fairness_token_control_bench;
  logic                                  core_clk_i = 1'b0;
  logic                                  rst_i = 1'b1;
  ring_fairness_pkg::cfg_t               cfg;
  ring_fairness_pkg::link_in_t           l0, l1;
  ring_fairness_pkg::link_in_t  [1:0]    lin;
  ring_fairness_pkg::link_out_t [1:0]    lo;
  logic                                  nf, nr, nc, nfl;
  int                                    fail_count = 0;
  int                                    n_checks = 0;
  initial forever #2.5 core_clk_i = ~core_clk_i;
  always_comb begin
    lin = {l1, l0};
    lin[0].rx_fair = nf;
    lin[0].rx_ret = nr;
    lin[0].char_valid = nc;
    lin[0].char_is_flag = nfl;
  end
  ring_fairness_token_control #(.CNT_SAT(12'h007)) dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_i(cfg),
    .link_i(lin), .link_o(lo));
  ring_fairness_neighbor nb_u (.core_clk_i(core_clk_i), .fair_o(nf),
    .ret_o(nr), .char_o(nc), .flag_o(nfl));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // gathers token pulses on port p over a bounded window
  task automatic seen(input int p, input logic [1:0] k);
    logic [1:0] hit;
    hit = 2'h0;
    repeat (10) begin
      @(negedge core_clk_i);
      hit |= {lo[p].tx_ret, lo[p].tx_fair};
    end
    chk({10'h0, hit}, {10'h0, k});
  endtask : seen
  task automatic frm(input int n, input logic ab);
    repeat (n) begin
      @(negedge core_clk_i);
      l0.frame_done = 1'b1;
      l0.frame_abort = ab;
      @(negedge core_clk_i);
      l0.frame_done = 1'b0;
    end
  endtask : frm
  task automatic t_forward;
    nb_u.tok(1'b0);
    seen(1, 2'h1);
    nb_u.tok(1'b1);
    seen(1, 2'h2);
  endtask : t_forward
  task automatic t_quota;
    l0.have_frames = 1'b1;
    l0.outstanding = 4'h2;
    frm(3, 1'b0);
    frm(1, 1'b1);
    chk(lo[0].frame_count, 12'h003);
    nb_u.tok(1'b0);
    repeat (3) @(negedge core_clk_i);
    chk({11'h0, lo[0].holding}, 12'h001);
    chk({11'h0, lo[0].may_originate}, 12'h001);
    frm(1, 1'b0);
    seen(1, 2'h1);
    chk(lo[0].frame_count, 12'h000);
    l0.have_frames = 1'b0;
    l0.outstanding = 4'h1;
  endtask : t_quota
  task automatic t_reflect;
    cfg.reflect = 1'b1;
    nb_u.tok(1'b0);
    seen(0, 2'h2);
    nb_u.tok(1'b1);
    seen(0, 2'h1);
    cfg.reflect = 1'b0;
  endtask : t_reflect
  task automatic t_string_end;
    l1.operational = 1'b0;
    frm(2, 1'b0);
    nb_u.tok(1'b1);
    seen(0, 2'h1);
    chk(lo[0].frame_count, 12'h002);
    nb_u.tok(1'b0);
    seen(0, 2'h2);
    l1.operational = 1'b1;
  endtask : t_string_end
  task automatic t_idle;
    nb_u.chr(1'b1);
    nb_u.chr(1'b1);
    chk({11'h0, lo[0].link_idle}, 12'h001);
    @(negedge core_clk_i);
    chk({11'h0, lo[0].may_originate}, 12'h001);
    l0.fwd_pending = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk({11'h0, lo[0].may_originate}, 12'h000);
    l0.fwd_pending = 1'b0;
    frm(3, 1'b0);
    @(negedge core_clk_i);
    chk({11'h0, lo[0].may_originate}, 12'h000);
    frm(6, 1'b0);
    chk(lo[0].frame_count, 12'h007);
    nb_u.chr(1'b0);
  endtask : t_idle
  task automatic t_port1;
    cfg.hold_base = 8'h01;
    l1.have_frames = 1'b1;
    l1.outstanding = 4'h2;
    @(negedge core_clk_i);
    l1.frame_done = 1'b1;
    l1.frame_abort = 1'b0;
    @(negedge core_clk_i);
    l1.frame_abort = 1'b1;
    @(negedge core_clk_i);
    l1.frame_done = 1'b0;
    l1.frame_abort = 1'b0;
    chk(lo[1].frame_count, 12'h001);
    l1.rx_fair = 1'b1;
    @(negedge core_clk_i);
    l1.rx_fair = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk({11'h0, lo[1].holding}, 12'h001);
    l1.frame_done = 1'b1;
    @(negedge core_clk_i);
    l1.frame_done = 1'b0;
    seen(0, 2'h1);
    chk(lo[1].frame_count, 12'h000);
    l1.rx_ret = 1'b1;
    @(negedge core_clk_i);
    l1.rx_ret = 1'b0;
    seen(0, 2'h2);
    repeat (2) begin
      @(negedge core_clk_i);
      l1.char_valid = 1'b1;
      l1.char_is_flag = 1'b1;
      @(negedge core_clk_i);
      l1.char_valid = 1'b0;
    end
    chk({11'h0, lo[1].link_idle}, 12'h001);
    l1.char_sync = 1'b0;
    @(negedge core_clk_i);
    l1.char_sync = 1'b1;
    chk({11'h0, lo[1].link_idle}, 12'h000);
    l1.char_is_flag = 1'b0;
    l1.have_frames = 1'b0;
    l1.outstanding = 4'h1;
    cfg.hold_base = 8'h02;
  endtask : t_port1
  task automatic t_not_ready;
    l1.ready = 1'b0;
    nb_u.tok(1'b0);
    seen(1, 2'h0);
    l1.ready = 1'b1;
    seen(1, 2'h1);
    l0.char_sync = 1'b0;
    nb_u.tok(1'b0);
    seen(1, 2'h0);
  endtask : t_not_ready
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    cfg = {8'h02, 8'h03, 1'b0};
    // sync, ready, operational set; one transfer outstanding
    l0 = 15'h7001;
    l1 = 15'h7001;
    repeat (20) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_forward();
    t_quota();
    t_reflect();
    t_string_end();
    t_idle();
    t_port1();
    t_not_ready();
    print_verdict();
  end
endmodule : ring_fairness_token_control_bench
